//--- shared/ffh_pkg.sv
// constants for the fall-through fifo host controller
package ffh_pkg;
  // clock period in picoseconds (250 MHz)
  localparam int unsigned CLK_PS = 4000;
  // device timing figures, nanoseconds
  localparam int unsigned PUSH_HIGH_MIN_NS = 45;
  localparam int unsigned PUSH_LOW_MIN_NS = 45;
  localparam int unsigned POP_HIGH_MIN_NS = 45;
  localparam int unsigned POP_LOW_MIN_NS = 45;
  localparam int unsigned DATA_SETUP_NS = 10;
  localparam int unsigned DATA_HOLD_NS = 55;
  localparam int unsigned CLEAR_PULSE_NS = 30;
  localparam int unsigned CLEAR_TO_PUSH_NS = 45;
  // fall-through time, microseconds
  localparam int unsigned FALLTHROUGH_TIME_US = 4;
  // least times round up to whole cycles
  localparam int unsigned PUSH_HIGH_CYC = (PUSH_HIGH_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned PUSH_LOW_CYC = (PUSH_LOW_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned POP_HIGH_CYC = (POP_HIGH_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned POP_LOW_CYC = (POP_LOW_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned SETUP_CYC = (DATA_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned HOLD_CYC = (DATA_HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned CLEAR_CYC = (CLEAR_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned CLEAR_GAP_CYC = (CLEAR_TO_PUSH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned FT_CYC = (FALLTHROUGH_TIME_US * 1000000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned CNT_W = 12;
  // word width and depth of the attached device
  localparam int unsigned WORD_W = 4;
  localparam int unsigned DEPTH = 64;

  typedef enum logic [5:0] {
    ST_CLEAR  = 6'b000001,
    ST_GAP    = 6'b000010,
    ST_IDLE   = 6'b000100,
    ST_SETUP  = 6'b001000,
    ST_HIGH   = 6'b010000,
    ST_LOW    = 6'b100000
  } ffh_wr_e;

  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_HIGH = 3'b010,
    RD_LOW  = 3'b100
  } ffh_rd_e;
endpackage

//--- logic/ffh_host.sv
// host controller driving a 64-word fall-through fifo through its pins
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module ffh_host #(
  parameter int unsigned WORD_W = ffh_pkg::WORD_W,
  parameter int unsigned LANES = 1,
  parameter int unsigned FT_CYC = ffh_pkg::FT_CYC
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  // user write side
  input wire logic [WORD_W*LANES-1:0] WR_DATA_IN,
  input wire logic WR_VALID_IN,
  output logic WR_READY_OUT,
  // user read side
  output logic [WORD_W*LANES-1:0] RD_DATA_OUT,
  output logic RD_VALID_OUT,
  input wire logic RD_READY_IN,
  // user status
  output logic FULL_OUT,
  output logic EMPTY_OUT,
  // device pins, one lane per device for width expansion
  output logic [WORD_W*LANES-1:0] WRITE_WORD_OUT,
  output logic PUSH_OUT,
  input wire logic [LANES-1:0] SPACE_AVAIL_IN,
  input wire logic [WORD_W*LANES-1:0] READ_WORD_IN,
  output logic POP_OUT,
  input wire logic [LANES-1:0] WORD_VALID_IN,
  output logic CLEAR_ALL_OUT
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [LANES-1:0] sp_m, sp_s, wv_m, wv_s;
  logic [WORD_W*LANES-1:0] rw_m, rw_s;
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      sp_m <= '0;
      sp_s <= '0;
      wv_m <= '0;
      wv_s <= '0;
      rw_m <= '0;
      rw_s <= '0;
    end else begin
      sp_m <= SPACE_AVAIL_IN;
      sp_s <= sp_m;
      wv_m <= WORD_VALID_IN;
      wv_s <= wv_m;
      rw_m <= READ_WORD_IN;
      rw_s <= rw_m;
    end
  end
  // composite flags across lanes
  logic all_sp_hi, all_sp_lo, all_wv_hi, all_wv_lo;
  assign all_sp_hi = &sp_s;
  assign all_sp_lo = ~|sp_s;
  assign all_wv_hi = &wv_s;
  assign all_wv_lo = ~|wv_s;

  // ---------------------------------------------------------------
  // write side: clear after reset, then push handshake
  // ---------------------------------------------------------------
  ffh_pkg::ffh_wr_e wst;
  logic [ffh_pkg::CNT_W-1:0] wcnt;
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      wst <= ffh_pkg::ST_CLEAR;
      wcnt <= '0;
      CLEAR_ALL_OUT <= 1'b1;
      PUSH_OUT <= 1'b0;
      WR_READY_OUT <= 1'b0;
      WRITE_WORD_OUT <= '0;
    end else begin
      WR_READY_OUT <= 1'b0;
      case (wst)
        ffh_pkg::ST_CLEAR: begin
          // pulse empties all cells, zeroes valid and the output word, and sets space high
          if (wcnt == ffh_pkg::CNT_W'(ffh_pkg::CLEAR_CYC - 1)) begin
            CLEAR_ALL_OUT <= 1'b0;
            wcnt <= '0;
            wst <= ffh_pkg::ST_GAP;
          end else begin
            wcnt <= wcnt + 1'b1;
          end
        end
        ffh_pkg::ST_GAP: begin
          if (wcnt == ffh_pkg::CNT_W'(ffh_pkg::CLEAR_GAP_CYC - 1)) begin
            wst <= ffh_pkg::ST_IDLE;
            WR_READY_OUT <= 1'b1;
          end else begin
            wcnt <= wcnt + 1'b1;
          end
        end
        ffh_pkg::ST_IDLE: begin
          // ready pulse accepts one word; push only with all flags high
          if (WR_VALID_IN && WR_READY_OUT) begin
            WRITE_WORD_OUT <= WR_DATA_IN;
            wcnt <= '0;
            wst <= ffh_pkg::ST_SETUP;
          end else if (!WR_READY_OUT) begin
            WR_READY_OUT <= 1'b1;
          end
        end
        ffh_pkg::ST_SETUP: begin
          if (wcnt >= ffh_pkg::CNT_W'(ffh_pkg::SETUP_CYC) && all_sp_hi) begin
            PUSH_OUT <= 1'b1;
            wcnt <= '0;
            wst <= ffh_pkg::ST_HIGH;
          end else if (wcnt < ffh_pkg::CNT_W'(ffh_pkg::SETUP_CYC)) begin
            wcnt <= wcnt + 1'b1;
          end
        end
        ffh_pkg::ST_HIGH: begin
          // hold until min high and data hold met, and all lanes took it
          if (wcnt >= ffh_pkg::CNT_W'(ffh_pkg::HOLD_CYC) && all_sp_lo) begin
            PUSH_OUT <= 1'b0;
            wcnt <= '0;
            wst <= ffh_pkg::ST_LOW;
          end else if (wcnt < ffh_pkg::CNT_W'(ffh_pkg::HOLD_CYC)) begin
            wcnt <= wcnt + 1'b1;
          end
        end
        ffh_pkg::ST_LOW: begin
          if (wcnt == ffh_pkg::CNT_W'(ffh_pkg::PUSH_LOW_CYC - 1)) begin
            wst <= ffh_pkg::ST_IDLE;
          end else begin
            wcnt <= wcnt + 1'b1;
          end
        end
        default: begin
          wst <= ffh_pkg::ST_CLEAR;
          CLEAR_ALL_OUT <= 1'b1;
          PUSH_OUT <= 1'b0;
          wcnt <= '0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read side: pop handshake into a one-word holding register
  // ---------------------------------------------------------------
  ffh_pkg::ffh_rd_e rst;
  logic [ffh_pkg::CNT_W-1:0] rcnt;
  logic clearing;
  assign clearing = (wst == ffh_pkg::ST_CLEAR) || (wst == ffh_pkg::ST_GAP);
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      rst <= ffh_pkg::RD_IDLE;
      rcnt <= '0;
      POP_OUT <= 1'b0;
      RD_VALID_OUT <= 1'b0;
      RD_DATA_OUT <= '0;
    end else begin
      if (RD_VALID_OUT && RD_READY_IN) begin
        RD_VALID_OUT <= 1'b0;
      end
      case (rst)
        ffh_pkg::RD_IDLE: begin
          // data is stable once valid seen, two stages behind the pin
          if (!clearing && all_wv_hi && !RD_VALID_OUT) begin
            RD_DATA_OUT <= rw_s;
            RD_VALID_OUT <= 1'b1;
            POP_OUT <= 1'b1;
            rcnt <= '0;
            rst <= ffh_pkg::RD_HIGH;
          end
        end
        ffh_pkg::RD_HIGH: begin
          // valid drop on every lane confirms the pop was seen
          if (rcnt >= ffh_pkg::CNT_W'(ffh_pkg::POP_HIGH_CYC - 1) && all_wv_lo) begin
            POP_OUT <= 1'b0;
            rcnt <= '0;
            rst <= ffh_pkg::RD_LOW;
          end else if (rcnt < ffh_pkg::CNT_W'(ffh_pkg::POP_HIGH_CYC - 1)) begin
            rcnt <= rcnt + 1'b1;
          end
        end
        ffh_pkg::RD_LOW: begin
          // low time plus sync delay so a stale valid is not reused
          if (rcnt == ffh_pkg::CNT_W'(ffh_pkg::POP_LOW_CYC + 1)) begin
            rst <= ffh_pkg::RD_IDLE;
          end else begin
            rcnt <= rcnt + 1'b1;
          end
        end
        default: begin
          rst <= ffh_pkg::RD_IDLE;
          POP_OUT <= 1'b0;
          rcnt <= '0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // full and empty: flag low for the fall-through time; empty also set at once while clearing once all valid lanes read low
  // ---------------------------------------------------------------
  logic [31:0] sp_lo_cnt, wv_lo_cnt;
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      sp_lo_cnt <= '0;
      FULL_OUT <= 1'b0;
    end else begin
      if (all_sp_hi || clearing) begin
        sp_lo_cnt <= '0;
        FULL_OUT <= 1'b0;
      end else if (sp_lo_cnt >= 32'(FT_CYC)) begin
        FULL_OUT <= 1'b1;
      end else begin
        sp_lo_cnt <= sp_lo_cnt + 1;
      end
    end
  end
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      wv_lo_cnt <= '0;
      EMPTY_OUT <= 1'b1;
    end else begin
      if (!all_wv_lo) begin
        wv_lo_cnt <= '0;
        EMPTY_OUT <= 1'b0;
      end else if (clearing) begin
        EMPTY_OUT <= 1'b1;
      end else if (wv_lo_cnt >= 32'(FT_CYC)) begin
        EMPTY_OUT <= 1'b1;
      end else begin
        wv_lo_cnt <= wv_lo_cnt + 1;
      end
    end
  end
endmodule

//--- test/ffh_host_asserts.sv
// port assertions for the fifo host controller
module ffh_host_asserts #(
  parameter int unsigned WORD_W = 4,
  parameter int unsigned LANES = 1,
  parameter int unsigned FT_CYC = 1000
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  // device pins and status
  // (flags reach the strobes three samples late: two sync stages)
  input wire logic [WORD_W*LANES-1:0] WRITE_WORD_OUT,
  input wire logic PUSH_OUT,
  input wire logic [LANES-1:0] SPACE_AVAIL_IN,
  input wire logic POP_OUT,
  input wire logic [LANES-1:0] WORD_VALID_IN,
  input wire logic CLEAR_ALL_OUT,
  input wire logic EMPTY_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // raw low run of valid, saturates so it never wraps
  logic [11:0] lo_v;
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) lo_v <= 12'h000;
    else if (|WORD_VALID_IN) lo_v <= 12'h000;
    else if (lo_v != 12'hFFF) lo_v <= lo_v + 12'h001;
  end
  sequence push_held;
    PUSH_OUT [*8] ##1 PUSH_OUT [*6];
  endsequence
  sequence pop_rest;
    !POP_OUT [*8] ##1 !POP_OUT [*6];
  endsequence
  a_push_space:
    assert property ($rose(PUSH_OUT) |-> $past(&SPACE_AVAIL_IN, 3))
    else $error("push without space");
  a_pop_valid:
    assert property ($rose(POP_OUT) |-> $past(&WORD_VALID_IN, 3))
    else $error("pop without valid");
  a_push_hold:
    assert property ($rose(PUSH_OUT) |-> push_held)
    else $error("push too short");
  a_pop_hold:
    assert property ($rose(POP_OUT) |-> POP_OUT [*8] ##1 POP_OUT [*4])
    else $error("pop too short");
  a_pop_rest:
    assert property ($fell(POP_OUT) |-> pop_rest)
    else $error("pop low too short");
  a_clear_start:
    assert property ($fell(SYS_RST_IN) |-> CLEAR_ALL_OUT [*7])
    else $error("clear too short");
  a_clear_quiet:
    assert property (CLEAR_ALL_OUT |-> !PUSH_OUT && !POP_OUT)
    else $error("strobe during clear");
  a_word_steady:
    assert property (PUSH_OUT |-> $stable(WRITE_WORD_OUT))
    else $error("word moved during push");
  a_empty_time:
    assert property ($rose(EMPTY_OUT) |-> lo_v >= FT_CYC)
    else $error("empty too early");
endmodule
bind ffh_host ffh_host_asserts #(.WORD_W(WORD_W), .LANES(LANES),
  .FT_CYC(FT_CYC)) chk_u (.CLK_IN, .SYS_RST_IN, .WRITE_WORD_OUT,
  .PUSH_OUT, .SPACE_AVAIL_IN, .POP_OUT, .WORD_VALID_IN, .CLEAR_ALL_OUT,
  .EMPTY_OUT);

//--- test/ffh_dev_model.sv
// behavioural model of the 64x4 fall-through device
module ffh_dev_model #(
  parameter int DLY = 3
) (
  // device pins
  input wire logic clk_in,
  input wire logic clear_in,
  input wire logic push_in,
  input wire logic [3:0] word_in,
  input wire logic pop_in,
  output logic space_out,
  output logic valid_out,
  output logic [3:0] word_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] mem[$];
  logic push_d = 1'b0;
  logic pop_d = 1'b0;
  logic busy = 1'b0;
  int t = 0;
  // queue packs words at the output end
  always @(posedge clk_in) begin
    push_d <= push_in;
    pop_d <= pop_in;
    if (clear_in) begin
      mem.delete();
      space_out <= 1'b1;
      valid_out <= 1'b0;
      word_out <= 4'h0;
      busy <= 1'b0;
      t <= 0;
    end else begin
      if (push_in && !push_d && space_out) begin
        mem.push_back(word_in);
        space_out <= 1'b0;
      end else if (!push_in && mem.size() < 64) begin
        space_out <= 1'b1;
      end
      if (pop_in && !pop_d && valid_out) begin
        valid_out <= 1'b0;
        busy <= 1'b1;
      end else if (!pop_in && busy) begin
        void'(mem.pop_front());
        busy <= 1'b0;
      end else if (!pop_in && !valid_out && mem.size() > 0) begin
        t <= (t == DLY) ? 0 : t + 1;
        if (t == DLY) begin
          valid_out <= 1'b1;
          word_out <= mem[0];
        end
      end
    end
  end
endmodule

//--- test/test_ffh_host.sv
// self-checking bench for the fifo host controller
module test_ffh_host;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_valid = 1'b0;
  logic rd_ready = 1'b0;
  logic [3:0] wr_data = 4'h0;
  logic [3:0] rd_data, w_word, r_word;
  logic wr_ready, rd_valid, full, empty, push, pop, clr, space, valid;
  logic [3:0] q[$];
  int miscompares = 0;
  int tests_run = 0;
  always #2 clk = ~clk;
  ffh_host #(.FT_CYC(20)) dut_u (.CLK_IN(clk), .SYS_RST_IN(rst),
    .WR_DATA_IN(wr_data), .WR_VALID_IN(wr_valid),
    .WR_READY_OUT(wr_ready), .RD_DATA_OUT(rd_data),
    .RD_VALID_OUT(rd_valid), .RD_READY_IN(rd_ready), .FULL_OUT(full),
    .EMPTY_OUT(empty), .WRITE_WORD_OUT(w_word), .PUSH_OUT(push),
    .SPACE_AVAIL_IN(space), .READ_WORD_IN(r_word), .POP_OUT(pop),
    .WORD_VALID_IN(valid), .CLEAR_ALL_OUT(clr));
  ffh_dev_model dev_u (.clk_in(clk), .clear_in(clr), .push_in(push),
    .word_in(w_word), .pop_in(pop), .space_out(space),
    .valid_out(valid), .word_out(r_word));
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // bounded waits so a refusal cannot hang the run
  task automatic put(input logic [3:0] d, output logic ok);
    @(posedge clk);
    wr_data <= d;
    wr_valid <= 1'b1;
    ok = 1'b0;
    for (int n = 0; n < 300 && !ok; n++) begin
      @(posedge clk);
      ok = (wr_ready === 1'b1);
    end
    wr_valid <= 1'b0;
    if (ok) q.push_back(d);
  endtask
  task automatic drain();
    logic ok;
    while (q.size() > 0) begin
      @(posedge clk);
      rd_ready <= 1'b1;
      ok = 1'b0;
      for (int n = 0; n < 300 && !ok; n++) begin
        @(posedge clk);
        ok = (rd_valid === 1'b1);
        if (ok) chk(rd_data === q[0], "read word");
      end
      chk(ok, "no read");
      rd_ready <= 1'b0;
      void'(q.pop_front());
    end
    repeat (60) @(posedge clk);
    chk(empty === 1'b1, "not empty");
    chk(rd_valid === 1'b0, "stale read");
  endtask
  task automatic t_reset();
    chk(empty === 1'b1 && full === 1'b0, "flags at reset");
    chk(rd_valid === 1'b0, "read at reset");
  endtask
  task automatic t_order();
    logic ok;
    for (int i = 0; i < 5; i++) begin
      put(4'(i * 7 + 3), ok);
      chk(ok, "write refused");
    end
    drain();
  endtask
  task automatic t_fill();
    logic ok;
    int n = 0;
    // device cells plus the read holding word plus one word parked
    // in the controller waiting for space; the last put is refused
    for (int i = 0; i < ffh_pkg::DEPTH + 3; i++) begin
      put(4'(i) ^ 4'h5, ok);
      n += int'(ok);
    end
    chk(n == ffh_pkg::DEPTH + 2, "depth");
    chk(full === 1'b1, "full flag");
    drain();
  endtask
  task automatic t_mid_reset();
    logic ok;
    put(4'h9, ok);
    put(4'h6, ok);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    q.delete();
    repeat (60) @(posedge clk);
    chk(empty === 1'b1 && rd_valid === 1'b0, "kept over reset");
    put(4'hC, ok);
    drain();
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_order();
    t_fill();
    t_mid_reset();
    stop_test();
  end
  initial begin
    #120000;
    miscompares++;
    $display("[FAIL] %0t watchdog", $time);
    stop_test();
  end
endmodule
